// [verif/test_xbc_ext_bus_ctrl.sv]
// self-checking bench of the external bus controller
`timescale 1ns/1ps
`default_nettype none
module test_xbc_ext_bus_ctrl;
  import xbc_pkg::*;
  logic clk, rst, bus_clk, req_valid, req_ready, req_write, req_byte, resp_valid, mux, d8;
  logic opb_req, opb_write, opb_byte, opb_done, ref_clock_out, addr_port_oe, ale_o, rd_n_o;
  logic wr_n_o, bhe_n_o, strobe_oe, ready_i, arb_enable, hold_n_i, hold_ack_n_o, hold_ack_oe;
  logic bus_request_n_o, bus_request_oe, arb_slave, hold_ack_n_i;
  xbc_addr_t req_addr;
  xbc_data_t req_wdata, resp_rdata, opb_wdata, opb_rdata, data_port_o, data_port_i;
  xbc_data_t addr_port_o, rd;
  logic [1:0] data_port_oe;
  logic [10:0] opb_addr, got_opb;
  logic [7:0] seg_port_o, seg_port_oe, seen_seg;
  logic [4:0] cs_n_o, seen_cs, cs_resp;
  xbc_wsel_t wsel;
  xbc_tcfg_t tcfg;
  xbc_fcfg_t fcfg;
  logic [5:0] dtcfg, dfcfg;
  logic [2:0] seg_lines;
  int num_errors, comparisons, n;
  xbc_ext_bus_ctrl i_xbc_ext_bus_ctrl (.clk, .rst, .bus_clk, .req_valid, .req_ready,
    .req_addr, .req_wdata, .req_write, .req_byte, .resp_valid, .resp_rdata,
    .window_addr_select(wsel), .window_timing_cfg(tcfg), .window_function_cfg(fcfg),
    .default_timing_cfg(dtcfg), .default_function_cfg(dfcfg), .seg_lines, .arb_enable,
    .arb_slave, .opb_req, .opb_write, .opb_byte, .opb_addr, .opb_wdata, .opb_rdata,
    .opb_done, .ref_clock_out, .data_port_o, .data_port_oe, .data_port_i, .addr_port_o,
    .addr_port_oe, .seg_port_o, .seg_port_oe, .cs_n_o, .ale_o, .rd_n_o, .wr_n_o, .bhe_n_o,
    .strobe_oe, .ready_i, .hold_n_i, .hold_ack_n_o, .hold_ack_oe, .hold_ack_n_i,
    .bus_request_n_o, .bus_request_oe);
  xbc_ext_mem i_xbc_ext_mem (.bus_clk, .addr_port_o, .data_port_o, .cs_n_o, .ale_o, .rd_n_o,
    .wr_n_o, .bhe_n_o, .mux, .d8, .data_port_i, .ready_i);
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    bus_clk = 0;
    #37;
    forever #80 bus_clk = ~bus_clk;
  end
  always @(posedge bus_clk)
  begin
    seen_cs = seen_cs | (~cs_n_o & {5{strobe_oe}});
    seen_seg = seen_seg | seg_port_oe;
  end
  // on-chip peripheral answering two cycles late
  initial
  begin
    opb_done = 0;
    opb_rdata = 16'h0000;
    forever
    begin
      @(posedge clk iff opb_req);
      got_opb = opb_addr;
      repeat (2) @(posedge clk);
      #1 opb_done = 1;
      opb_rdata = 16'hBEEF;
      @(posedge clk);
      #1 opb_done = 0;
      @(posedge clk);
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic acc(input xbc_addr_t a, input xbc_data_t wd, input logic wr, input logic by,
    input logic m, input logic b8, input logic [4:0] cs_exp);
    n = 0;
    @(posedge clk);
    #1;
    mux = m;
    d8 = b8;
    seen_cs = 5'h00;
    seen_seg = 8'h00;
    req_addr = a;
    req_wdata = wd;
    req_write = wr;
    req_byte = by;
    req_valid = 1;
    while (req_ready !== 1'b1 && n < 20000) begin @(posedge clk); #1; n++; end
    @(posedge clk);
    #1;
    req_valid = 0;
    while (resp_valid !== 1'b1 && n < 40000) begin @(posedge clk); #1; n++; end
    rd = resp_rdata;
    cs_resp = seen_cs;
    while (req_ready !== 1'b1 && n < 60000) begin @(posedge clk); #1; n++; end
    chk("chip selects", {11'h000, cs_exp}, {11'h000, seen_cs});
  endtask
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #300000;
    num_errors++;
    give_verdict;
  end
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    num_errors = 0;
    comparisons = 0;
    rst = 1;
    {req_valid, req_write, req_byte, mux, d8, arb_enable, arb_slave} = 7'h00;
    {hold_n_i, hold_ack_n_i} = 2'h3;
    req_addr = 24'h000000;
    req_wdata = 16'h0000;
    {seen_cs, seen_seg} = 13'h0000;
    wsel = {16'h0401, 16'h1400, 16'h0011, 16'h1010};
    tcfg = {6'h01, 6'h00, 6'h11, 6'h02};
    fcfg = {6'h0C, 6'h0B, 6'h0A, 6'h19};
    dtcfg = 6'h00;
    dfcfg = 6'h09;
    seg_lines = 3'h3;
    repeat (5) @(posedge bus_clk);
    #1 rst = 0;
    acc(24'h010002, 16'hA55A, 1, 0, 0, 0, 5'h02);
    acc(24'h010003, 16'hEEEE, 1, 1, 0, 0, 5'h02);
    acc(24'h010002, 16'h0000, 0, 0, 0, 0, 5'h02);
    chk("word after odd byte", 16'hEE5A, rd);
    chk("segment enables", 16'h0007, {8'h00, seen_seg});
    acc(24'h011004, 16'h3CC3, 1, 0, 1, 0, 5'h04);
    acc(24'h011004, 16'h0000, 0, 0, 1, 0, 5'h04);
    chk("mux word", 16'h3CC3, rd);
    acc(24'h400011, 16'h005A, 1, 1, 1, 1, 5'h08);
    acc(24'h400011, 16'h0000, 0, 1, 1, 1, 5'h08);
    chk("8-bit mux byte", 16'h005A, {8'h00, rd[7:0]});
    acc(24'h401013, 16'h0096, 1, 1, 0, 1, 5'h10);
    acc(24'h401013, 16'h0000, 0, 1, 0, 1, 5'h10);
    chk("8-bit demux byte", 16'h0096, {8'h00, rd[7:0]});
    acc(24'h020006, 16'h1234, 1, 0, 0, 0, 5'h01);
    acc(24'h200810, 16'h7777, 1, 0, 0, 0, 5'h01);
    chk("io write done before answer", 16'h0001, {11'h000, cs_resp});
    acc(24'h200010, 16'h0000, 0, 0, 0, 0, 5'h00);
    chk("on-chip read", 16'hBEEF, rd);
    chk("on-chip address", 16'h0010, {5'h00, got_opb});
    dfcfg = 6'h00;
    acc(24'h020000, 16'h0000, 0, 0, 0, 0, 5'h00);
    chk("single-chip read", 16'h0000, rd);
    dfcfg = 6'h09;
    arb_enable = 1;
    hold_n_i = 0;
    n = 0;
    while (hold_ack_n_o !== 1'b0 && n < 5000) begin @(posedge clk); #1; n++; end
    chk("hold ack", 16'h0006, {13'h0000, bus_request_oe, hold_ack_oe, hold_ack_n_o});
    chk("floated", 16'h0000, {12'h000, addr_port_oe, strobe_oe, data_port_oe});
    hold_n_i = 1;
    acc(24'h020006, 16'h0000, 0, 0, 0, 0, 5'h01);
    chk("read after hold", 16'h1234, rd);
    arb_slave = 1;
    repeat (8) @(posedge bus_clk);
    #1 chk("slave idle", 16'h0000, {14'h0000, hold_ack_oe, strobe_oe});
    hold_ack_n_i = 0;
    acc(24'h020006, 16'h0000, 0, 0, 0, 0, 5'h01);
    chk("slave read", 16'h1234, rd);
    give_verdict;
  end
endmodule // test_xbc_ext_bus_ctrl
`default_nettype wire

// [verif/xbc_ext_bus_ctrl_assertions.sv]
// concurrent checks on the pins of the external bus controller
`timescale 1ns/1ps
`default_nettype none
module xbc_eb_assertions (
  // clocks and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic bus_clk,
  // cpu and on-chip bus side
  input wire logic resp_valid,
  input wire logic opb_req,
  input wire logic opb_done,
  input wire logic [10:0] opb_addr,
  input wire logic arb_enable,
  // external pins
  input wire logic ref_clock_out,
  input wire logic [1:0] data_port_oe,
  input wire xbc_pkg::xbc_data_t addr_port_o,
  input wire logic addr_port_oe,
  input wire logic [4:0] cs_n_o,
  input wire logic rd_n_o,
  input wire logic wr_n_o,
  input wire logic strobe_oe,
  input wire logic hold_ack_n_o,
  input wire logic hold_ack_oe,
  input wire logic bus_request_oe
);
  import xbc_pkg::*;
  //////////////////////////////////////////////////////////////////////////////
  strobe_excl_a: assert property (@(posedge bus_clk) disable iff (rst)
    !(!rd_n_o && !wr_n_o)) else $error("read and write strobes low together");
  cs_onehot_a: assert property (@(posedge bus_clk) disable iff (rst)
    $countones(~cs_n_o) <= 1) else $error("more than one chip select low");
  edge_timing_a: assert property (@(posedge bus_clk) disable iff (rst)
    ($changed(cs_n_o) || $changed(rd_n_o) || $changed(wr_n_o)) |-> ref_clock_out)
    else $error("bus pin changed off the reference clock rise");
  wait_stable_a: assert property (@(posedge bus_clk) disable iff (rst)
    (!rd_n_o && addr_port_oe ##1 !rd_n_o) |-> $stable(addr_port_o) && $stable(cs_n_o))
    else $error("address or select moved during a stretched read");
  hold_float_a: assert property (@(posedge bus_clk) disable iff (rst)
    (hold_ack_oe && !hold_ack_n_o) |-> !strobe_oe && !addr_port_oe && data_port_oe == 2'h0)
    else $error("bus driven while hold acknowledged");
  arb_idle_a: assert property (@(posedge bus_clk) disable iff (rst)
    (!arb_enable && !$past(arb_enable, 4)) |-> !hold_ack_oe && !bus_request_oe)
    else $error("arbitration pins driven while arbitration off");
  opb_answer_a: assert property (@(posedge clk) disable iff (rst)
    opb_done |=> resp_valid && !opb_req) else $error("on-chip answer not forwarded");
  opb_hold_a: assert property (@(posedge clk) disable iff (rst)
    (opb_req && !opb_done) |=> opb_req && $stable(opb_addr))
    else $error("on-chip request dropped or changed early");
endmodule // xbc_eb_assertions
bind xbc_ext_bus_ctrl xbc_eb_assertions i_xbc_eb_assertions (.clk, .rst, .bus_clk,
  .resp_valid, .opb_req, .opb_done, .opb_addr, .arb_enable, .ref_clock_out, .data_port_oe,
  .addr_port_o, .addr_port_oe, .cs_n_o, .rd_n_o, .wr_n_o, .strobe_oe, .hold_ack_n_o,
  .hold_ack_oe, .bus_request_oe);
`default_nettype wire

// [verif/xbc_ext_mem.sv]
// behavioural external memory with a slow ready on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module xbc_ext_mem #(
  parameter int SLOW = 3,
  parameter logic RDY_POL = 1'b0
) (
  // link clock
  input wire logic bus_clk,
  // device pins
  input wire xbc_pkg::xbc_data_t addr_port_o,
  input wire xbc_pkg::xbc_data_t data_port_o,
  input wire logic [4:0] cs_n_o,
  input wire logic ale_o,
  input wire logic rd_n_o,
  input wire logic wr_n_o,
  input wire logic bhe_n_o,
  // lane setup of the access under way
  input wire logic mux,
  input wire logic d8,
  // answers
  output xbc_pkg::xbc_data_t data_port_i,
  output logic ready_i
);
  import xbc_pkg::*;
  logic [7:0] mem [0:127];
  logic [6:0] mux_a;
  logic [6:0] a;
  int cnt = 0;
  assign a = mux ? mux_a : addr_port_o[6:0];
  assign ready_i = (cnt >= SLOW) ? RDY_POL : ~RDY_POL;
  initial
  begin
    data_port_i = 16'h5A5A;
    for (int i = 0; i < 128; i++) mem[i] = 8'h00;
  end
  always @(posedge bus_clk)
  begin
    if (ale_o) mux_a <= data_port_o[6:0];
    cnt <= (rd_n_o && wr_n_o) ? 0 : cnt + 1;
    // released lane flips every cycle so a stale value never passes
    if (!rd_n_o && !(&cs_n_o))
      data_port_i <= {mem[a | 7'h01], mem[d8 ? a : (a & 7'h7E)]};
    else
      data_port_i <= ~data_port_i;
    if (!wr_n_o && !(&cs_n_o))
    begin
      if (d8 || !a[0]) mem[a] <= data_port_o[7:0];
      if (!d8 && !bhe_n_o) mem[a | 7'h01] <= data_port_o[15:8];
    end
  end
endmodule // xbc_ext_mem
`default_nettype wire

// [verilog/xbc_cfg.svh]
// constants of the external bus controller: widths, field positions, codes, address regions
`ifndef XBC_CFG_SVH
`define XBC_CFG_SVH
`define XBC_AW 24
`define XBC_DW 16
`define XBC_SEG_W 8
`define XBC_SET_N 5
`define XBC_WIN_N 4
`define XBC_TCFG_W 6
`define XBC_FCFG_W 6
`define XBC_WSEL_W 16
// timing set fields
`define XBC_WAIT_LSB 0
`define XBC_WAIT_W 4
`define XBC_SETUP_LSB 4
`define XBC_SETUP_W 2
// function set fields
`define XBC_MODE_LSB 0
`define XBC_MODE_W 3
`define XBC_WEN_BIT 3
`define XBC_RDYEN_BIT 4
`define XBC_RDYPOL_BIT 5
// window select fields
`define XBC_BASE_LSB 0
`define XBC_BASE_W 12
`define XBC_SIZE_LSB 12
`define XBC_SIZE_W 4
// bus mode codes
`define XBC_MODE_SINGLE 3'h0
`define XBC_MODE_D16_DMX 3'h1
`define XBC_MODE_D16_MUX 3'h2
`define XBC_MODE_D8_MUX 3'h3
`define XBC_MODE_D8_DMX 3'h4
// address regions
`define XBC_OPB_FIRST 24'h200000
`define XBC_OPB_LAST 24'h2007FF
`define XBC_IO_FIRST 24'h200800
`define XBC_IO_LAST 24'h3FFFFF
// idle pin levels
`define XBC_CS_IDLE 5'h1F
`endif

// [verilog/xbc_ext_bus_ctrl.sv]
// external bus controller: cpu request port, on-chip bus port and external bus engine
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - single-chip mode plus 16/8-bit data, multiplexed or not, 16 to 23 address bits
// - demultiplexed: address on address port, data on data port, low byte for 8-bit
// - multiplexed: data port carries address first, then data
// - segment lines on own port, count of active lines configurable
// - linear 16 Mbyte space, byte or word accesses
// - five active-low chip selects: four windows plus default
// - ready input stretches accesses, active level selectable
// - arbitration idle until enabled, then controller runs its pins
// - master after reset with hold-ack output; slave takes hold-ack as input
// - each access uses its window's timing and function set
// - window 4 beats 3, window 2 beats 1
// - no window hit selects set zero
// - chip select of the selected window asserted during the access
// - bus mode switches per access by the window hit
// - bus signals change with rising edge of reference clock output
// - on-chip peripheral bus region served like external components
// - external IO region accesses strictly in order, never posted
module xbc_ext_bus_ctrl (
  // clocks and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic bus_clk,
  // cpu access port
  input wire logic req_valid,
  output logic req_ready,
  input wire xbc_pkg::xbc_addr_t req_addr,
  input wire xbc_pkg::xbc_data_t req_wdata,
  input wire logic req_write,
  input wire logic req_byte,
  output logic resp_valid,
  output xbc_pkg::xbc_data_t resp_rdata,
  // configuration
  input wire xbc_pkg::xbc_wsel_t window_addr_select,
  input wire xbc_pkg::xbc_tcfg_t window_timing_cfg,
  input wire xbc_pkg::xbc_fcfg_t window_function_cfg,
  input wire logic [`XBC_TCFG_W-1:0] default_timing_cfg,
  input wire logic [`XBC_FCFG_W-1:0] default_function_cfg,
  input wire logic [2:0] seg_lines,
  input wire logic arb_enable,
  input wire logic arb_slave,
  // on-chip peripheral bus
  output logic opb_req,
  output logic opb_write,
  output logic opb_byte,
  output logic [10:0] opb_addr,
  output xbc_pkg::xbc_data_t opb_wdata,
  input wire xbc_pkg::xbc_data_t opb_rdata,
  input wire logic opb_done,
  // external bus pins
  output logic ref_clock_out,
  output xbc_pkg::xbc_data_t data_port_o,
  output logic [1:0] data_port_oe,
  input wire xbc_pkg::xbc_data_t data_port_i,
  output xbc_pkg::xbc_data_t addr_port_o,
  output logic addr_port_oe,
  output logic [`XBC_SEG_W-1:0] seg_port_o,
  output logic [`XBC_SEG_W-1:0] seg_port_oe,
  output logic [`XBC_SET_N-1:0] cs_n_o,
  output logic ale_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic bhe_n_o,
  output logic strobe_oe,
  input wire logic ready_i,
  // arbitration pins
  input wire logic hold_n_i,
  output logic hold_ack_n_o,
  output logic hold_ack_oe,
  input wire logic hold_ack_n_i,
  output logic bus_request_n_o,
  output logic bus_request_oe
);
  import xbc_pkg::*;

  function automatic logic in_range(input xbc_addr_t a, input xbc_addr_t lo, input xbc_addr_t hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [`XBC_SEG_W-1:0] seg_mask(input logic [2:0] n);
    return `XBC_SEG_W'((9'h001 << n) - 9'h001);
  endfunction

  function automatic logic is_mux(input xbc_mode_e m);
    return (m == XBC_D16_MUX) || (m == XBC_D8_MUX);
  endfunction

  function automatic logic is_wide(input xbc_mode_e m);
    return (m == XBC_D16_MUX) || (m == XBC_D16_DMX);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // window decode and configuration snapshot (clk domain)
  xbc_win_if win ();
  xbc_win_decode u_dec (.win(win.dec));

  logic [`XBC_TCFG_W-1:0] tsel;
  logic [`XBC_FCFG_W-1:0] fsel;
  xbc_req_s snap;
  logic [`XBC_WIN_N-1:0] wen;

  always_comb
  begin
    for (int i = 0; i < `XBC_WIN_N; i++)
    begin
      wen[i] = window_function_cfg[i][`XBC_WEN_BIT];
    end
  end

  assign win.addr = req_addr;
  assign win.sel = window_addr_select;
  assign win.wen = wen;

  always_comb
  begin
    tsel = default_timing_cfg;
    fsel = default_function_cfg;
    if (win.hit != 3'h0)
    begin
      tsel = window_timing_cfg[2'(win.hit - 3'h1)];
      fsel = window_function_cfg[2'(win.hit - 3'h1)];
    end
    snap.addr = req_addr;
    snap.wdata = req_wdata;
    snap.write = req_write;
    snap.byte_acc = req_byte;
    snap.mode = xbc_mode_e'(fsel[`XBC_MODE_LSB +: `XBC_MODE_W]);
    snap.waits = tsel[`XBC_WAIT_LSB +: `XBC_WAIT_W];
    snap.setup = tsel[`XBC_SETUP_LSB +: `XBC_SETUP_W];
    snap.rdy_en = fsel[`XBC_RDYEN_BIT];
    snap.rdy_pol = fsel[`XBC_RDYPOL_BIT];
    snap.set_idx = win.hit;
    snap.cs_en = (win.hit == 3'h0) || fsel[`XBC_WEN_BIT];
    snap.seg_lines = seg_lines;
  end

  //////////////////////////////////////////////////////////////////////////////
  // cpu side sequencing (clk domain)
  xbc_cst_e cst_q;
  xbc_req_s req_q;
  logic req_tgl_q;
  logic posted_q;
  logic [2:0] done_sync_q;
  logic done_tgl_q;
  xbc_data_t rd_data_q;
  logic accept;
  logic hit_opb;
  logic single;
  logic post_now;
  logic done_evt;

  assign accept = req_valid && req_ready;
  assign hit_opb = in_range(req_addr, `XBC_OPB_FIRST, `XBC_OPB_LAST);
  assign single = snap.mode == XBC_SINGLE;
  assign post_now = req_write && !in_range(req_addr, `XBC_IO_FIRST, `XBC_IO_LAST);
  assign done_evt = done_sync_q[2] ^ done_sync_q[1];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cst_q <= XBC_C_IDLE;
      req_ready <= 1'b1;
    end
    else
    begin
      case (cst_q)
        XBC_C_IDLE:
        begin
          if (accept && hit_opb)
          begin
            cst_q <= XBC_C_OPB;
            req_ready <= 1'b0;
          end
          else if (accept && !single)
          begin
            cst_q <= XBC_C_EXT;
            req_ready <= 1'b0;
          end
        end
        XBC_C_EXT:
        begin
          if (done_evt)
          begin
            cst_q <= XBC_C_IDLE;
            req_ready <= 1'b1;
          end
        end
        XBC_C_OPB:
        begin
          if (opb_done)
          begin
            cst_q <= XBC_C_IDLE;
            req_ready <= 1'b1;
          end
        end
        default:
        begin
          cst_q <= XBC_C_IDLE;
          req_ready <= 1'b1;
        end
      endcase
    end
  end

  // request words stay stable until the bus side toggles done
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      req_q <= '0;
      req_tgl_q <= 1'b0;
      posted_q <= 1'b0;
    end
    else if (accept && !hit_opb && !single)
    begin
      req_q <= snap;
      req_tgl_q <= ~req_tgl_q;
      posted_q <= post_now;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      done_sync_q <= 3'h0;
    end
    else
    begin
      done_sync_q <= {done_sync_q[1:0], done_tgl_q};
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      resp_valid <= 1'b0;
      resp_rdata <= 16'h0000;
    end
    else
    begin
      resp_valid <= 1'b0;
      if (accept && !hit_opb && (single || post_now))
      begin
        resp_valid <= 1'b1;
        resp_rdata <= 16'h0000;
      end
      else if (cst_q == XBC_C_EXT && done_evt && !posted_q)
      begin
        resp_valid <= 1'b1;
        resp_rdata <= rd_data_q;
      end
      else if (cst_q == XBC_C_OPB && opb_done)
      begin
        resp_valid <= 1'b1;
        resp_rdata <= opb_rdata;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      opb_req <= 1'b0;
      opb_write <= 1'b0;
      opb_byte <= 1'b0;
      opb_addr <= 11'h000;
      opb_wdata <= 16'h0000;
    end
    else if (accept && hit_opb)
    begin
      opb_req <= 1'b1;
      opb_write <= req_write;
      opb_byte <= req_byte;
      opb_addr <= req_addr[10:0];
      opb_wdata <= req_wdata;
    end
    else if (opb_done)
    begin
      opb_req <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus side synchronisers and pacing (bus_clk domain)
  logic [2:0] req_sync_q;
  logic [1:0] rdy_sync_q;
  logic [1:0] hold_sync_q;
  logic [1:0] hack_sync_q;
  logic [1:0] arb_sync_q;
  logic [1:0] slv_sync_q;
  logic pending_q;
  logic [`XBC_WAIT_W-1:0] cnt_q;
  xbc_bst_e bst_q;
  logic tick;
  logic arb_on;
  logic slave;
  logic hold_req;
  logic granted;
  logic start;
  logic rdy_ok;

  assign tick = ~ref_clock_out;
  assign arb_on = arb_sync_q[1];
  assign slave = slv_sync_q[1];
  assign hold_req = arb_on && !slave && !hold_sync_q[1];
  assign granted = !arb_on || !slave || !hack_sync_q[1];
  assign start = tick && bst_q == XBC_B_IDLE && pending_q && !hold_req && granted;
  assign rdy_ok = !req_q.rdy_en || (rdy_sync_q[1] == req_q.rdy_pol);

  always_ff @(posedge bus_clk or posedge rst)
  begin
    if (rst)
    begin
      req_sync_q <= 3'h0;
      rdy_sync_q <= 2'h0;
      hold_sync_q <= 2'h3;
      hack_sync_q <= 2'h3;
      arb_sync_q <= 2'h0;
      slv_sync_q <= 2'h0;
      ref_clock_out <= 1'b0;
    end
    else
    begin
      req_sync_q <= {req_sync_q[1:0], req_tgl_q};
      rdy_sync_q <= {rdy_sync_q[0], ready_i};
      hold_sync_q <= {hold_sync_q[0], hold_n_i};
      hack_sync_q <= {hack_sync_q[0], hold_ack_n_i};
      arb_sync_q <= {arb_sync_q[0], arb_enable};
      slv_sync_q <= {slv_sync_q[0], arb_slave};
      ref_clock_out <= ~ref_clock_out;
    end
  end

  // a new request sets pending even in the cycle an access starts
  always_ff @(posedge bus_clk or posedge rst)
  begin
    if (rst)
    begin
      pending_q <= 1'b0;
    end
    else if (req_sync_q[2] ^ req_sync_q[1])
    begin
      pending_q <= 1'b1;
    end
    else if (start)
    begin
      pending_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // external access engine (bus_clk domain)
  always_ff @(posedge bus_clk or posedge rst)
  begin
    if (rst)
    begin
      bst_q <= XBC_B_IDLE;
      cnt_q <= '0;
      data_port_o <= 16'h0000;
      data_port_oe <= 2'h0;
      addr_port_o <= 16'h0000;
      addr_port_oe <= 1'b0;
      seg_port_o <= 8'h00;
      seg_port_oe <= 8'h00;
      cs_n_o <= `XBC_CS_IDLE;
      ale_o <= 1'b0;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      bhe_n_o <= 1'b1;
      strobe_oe <= 1'b0;
      rd_data_q <= 16'h0000;
      done_tgl_q <= 1'b0;
      hold_ack_n_o <= 1'b1;
    end
    else if (tick)
    begin
      case (bst_q)
        XBC_B_IDLE:
        begin
          strobe_oe <= granted;
          if (hold_req)
          begin
            bst_q <= XBC_B_HOLD;
            hold_ack_n_o <= 1'b0;
            strobe_oe <= 1'b0;
            addr_port_oe <= 1'b0;
            seg_port_oe <= 8'h00;
            data_port_oe <= 2'h0;
          end
          else if (start)
          begin
            bst_q <= XBC_B_ADDR;
            cnt_q <= `XBC_WAIT_W'(req_q.setup);
            strobe_oe <= 1'b1;
            cs_n_o <= req_q.cs_en ? ~(5'h01 << req_q.set_idx) : `XBC_CS_IDLE;
            seg_port_o <= req_q.addr[`XBC_AW-1 -: `XBC_SEG_W] & seg_mask(req_q.seg_lines);
            seg_port_oe <= seg_mask(req_q.seg_lines);
            bhe_n_o <= req_q.byte_acc && !req_q.addr[0];
            if (is_mux(req_q.mode))
            begin
              data_port_o <= req_q.addr[15:0];
              data_port_oe <= 2'h3;
              addr_port_oe <= 1'b0;
              ale_o <= 1'b1;
            end
            else
            begin
              addr_port_o <= req_q.addr[15:0];
              addr_port_oe <= 1'b1;
              data_port_oe <= 2'h0;
            end
          end
        end
        XBC_B_ADDR:
        begin
          if (cnt_q != '0)
          begin
            cnt_q <= cnt_q - 1'b1;
          end
          else
          begin
            bst_q <= XBC_B_DATA;
            cnt_q <= req_q.waits;
            ale_o <= 1'b0;
            if (req_q.write)
            begin
              data_port_o <= (req_q.byte_acc && req_q.addr[0] && is_wide(req_q.mode))
                ? {req_q.wdata[7:0], req_q.wdata[7:0]} : req_q.wdata;
              data_port_oe <= is_wide(req_q.mode) ? 2'h3 : 2'h1;
              wr_n_o <= 1'b0;
            end
            else
            begin
              data_port_oe <= 2'h0;
              rd_n_o <= 1'b0;
            end
          end
        end
        XBC_B_DATA:
        begin
          if (cnt_q != '0)
          begin
            cnt_q <= cnt_q - 1'b1;
          end
          else if (rdy_ok)
          begin
            bst_q <= XBC_B_END;
            rd_n_o <= 1'b1;
            wr_n_o <= 1'b1;
            if (req_q.byte_acc && req_q.addr[0] && is_wide(req_q.mode))
            begin
              rd_data_q <= {8'h00, data_port_i[15:8]};
            end
            else if (req_q.byte_acc || !is_wide(req_q.mode))
            begin
              rd_data_q <= {8'h00, data_port_i[7:0]};
            end
            else
            begin
              rd_data_q <= data_port_i;
            end
          end
        end
        XBC_B_END:
        begin
          bst_q <= XBC_B_IDLE;
          cs_n_o <= `XBC_CS_IDLE;
          bhe_n_o <= 1'b1;
          data_port_oe <= 2'h0;
          done_tgl_q <= ~done_tgl_q;
        end
        XBC_B_HOLD:
        begin
          if (!hold_req)
          begin
            bst_q <= XBC_B_IDLE;
            hold_ack_n_o <= 1'b1;
            strobe_oe <= 1'b1;
          end
        end
        default:
        begin
          bst_q <= XBC_B_IDLE;
        end
      endcase
    end
  end

  // arbitration pin ownership
  always_ff @(posedge bus_clk or posedge rst)
  begin
    if (rst)
    begin
      hold_ack_oe <= 1'b0;
      bus_request_n_o <= 1'b1;
      bus_request_oe <= 1'b0;
    end
    else
    begin
      hold_ack_oe <= arb_on && !slave;
      bus_request_oe <= arb_on;
      bus_request_n_o <= !(arb_on && pending_q && (slave ? !granted : bst_q == XBC_B_HOLD));
    end
  end
endmodule // xbc_ext_bus_ctrl
`default_nettype wire

// [verilog/xbc_pkg.sv]
// types of the external bus controller
package xbc_pkg;
`include "xbc_cfg.svh"
  typedef logic [`XBC_AW-1:0] xbc_addr_t;
  typedef logic [`XBC_DW-1:0] xbc_data_t;
  typedef logic [`XBC_WIN_N-1:0][`XBC_WSEL_W-1:0] xbc_wsel_t;
  typedef logic [`XBC_WIN_N-1:0][`XBC_TCFG_W-1:0] xbc_tcfg_t;
  typedef logic [`XBC_WIN_N-1:0][`XBC_FCFG_W-1:0] xbc_fcfg_t;
  typedef enum logic [2:0] {
    XBC_SINGLE = `XBC_MODE_SINGLE,
    XBC_D16_DMX = `XBC_MODE_D16_DMX,
    XBC_D16_MUX = `XBC_MODE_D16_MUX,
    XBC_D8_MUX = `XBC_MODE_D8_MUX,
    XBC_D8_DMX = `XBC_MODE_D8_DMX
  } xbc_mode_e;
  typedef enum logic [2:0] {
    XBC_C_IDLE = 3'b001,
    XBC_C_EXT = 3'b010,
    XBC_C_OPB = 3'b100
  } xbc_cst_e;
  typedef enum logic [4:0] {
    XBC_B_IDLE = 5'b00001,
    XBC_B_ADDR = 5'b00010,
    XBC_B_DATA = 5'b00100,
    XBC_B_END = 5'b01000,
    XBC_B_HOLD = 5'b10000
  } xbc_bst_e;
  typedef struct packed {
    xbc_addr_t addr;
    xbc_data_t wdata;
    logic write;
    logic byte_acc;
    xbc_mode_e mode;
    logic [`XBC_WAIT_W-1:0] waits;
    logic [`XBC_SETUP_W-1:0] setup;
    logic rdy_en;
    logic rdy_pol;
    logic [2:0] set_idx;
    logic cs_en;
    logic [2:0] seg_lines;
  } xbc_req_s;
endpackage

// [verilog/xbc_win_decode.sv]
// address window decoder: picks the configuration set for an address
`timescale 1ns/1ps
`default_nettype none
module xbc_win_decode (
  // window carrier
  xbc_win_if.dec win
);
  import xbc_pkg::*;

  // window covers 4 Kbytes shifted left by the size code
  function automatic logic win_match(input xbc_addr_t a, input logic [`XBC_WSEL_W-1:0] s);
    logic [`XBC_BASE_W-1:0] mask;
    mask = 12'hFFF << s[`XBC_SIZE_LSB +: `XBC_SIZE_W];
    return ((a[`XBC_AW-1 -: `XBC_BASE_W] ^ s[`XBC_BASE_LSB +: `XBC_BASE_W]) & mask) == 12'h000;
  endfunction

  // later windows override earlier ones; no hit means set zero
  always_comb
  begin
    win.hit = 3'h0;
    for (int i = 0; i < `XBC_WIN_N; i++)
    begin
      if (win.wen[i] && win_match(win.addr, win.sel[i]))
      begin
        win.hit = 3'(i + 1);
      end
    end
  end
endmodule // xbc_win_decode
`default_nettype wire

// [verilog/xbc_win_if.sv]
// carrier between the controller and its address window decoder
`timescale 1ns/1ps
`default_nettype none
interface xbc_win_if;
  import xbc_pkg::*;
  xbc_addr_t addr;
  xbc_wsel_t sel;
  logic [`XBC_WIN_N-1:0] wen;
  logic [2:0] hit;
  modport dec (input addr, input sel, input wen, output hit);
  modport host (output addr, output sel, output wen, input hit);
endinterface
`default_nettype wire
